// File: prot_ind_pkg.sv
// Shared constants and types for the protection indication block
package prot_ind_pkg;
	localparam int DW = 16;
	localparam int AW = 5;
	// Register indices
	localparam logic [4:0] REG_CMD      = 5'h00;
	localparam logic [4:0] REG_FUNC1    = 5'h01;
	localparam logic [4:0] REG_FUNC2    = 5'h02;
	localparam logic [4:0] REG_FUNC3    = 5'h03;
	localparam logic [4:0] REG_BLOCK1   = 5'h04;
	localparam logic [4:0] REG_ROUTE1   = 5'h05;
	localparam logic [4:0] REG_DSEL     = 5'h06;
	localparam logic [4:0] REG_IRQ_STAT = 5'h07;
	localparam logic [4:0] REG_IRQ_MASK = 5'h08;
	localparam logic [4:0] REG_IND      = 5'h09;
	localparam logic [4:0] REG_RECORD   = 5'h0a;
	localparam logic [4:0] REG_SET0     = 5'h10;
	localparam int         NSET         = 9;
	// Command bits
	localparam int CMD_KEEP  = 0;
	localparam int CMD_ERASE = 1;
	// Switch fields
	localparam int FUNC1_CHAR_LSB = 0;
	localparam int FUNC1_HS_INF   = 6;
	localparam int FUNC1_HEF_INF  = 7;
	// Interrupt bits
	localparam int IRQ_START = 0;
	localparam int IRQ_TRIP  = 1;
	localparam int IRQ_ALARM = 2;
	localparam int NIRQ      = 3;
	// Setting index, units in comments
	localparam int S_LS_START = 0; // 0.1 x In
	localparam int S_LS_TIME  = 1; // 10 ms
	localparam int S_LS_MULT  = 2; // 0.01
	localparam int S_HS_START = 3; // 0.1 x In
	localparam int S_HS_TIME  = 4; // 10 ms
	localparam int S_RV_START = 5; // 0.1 % Un
	localparam int S_LE_START = 6; // 0.1 % In
	localparam int S_LE_TIME  = 7; // 10 ms
	localparam int S_HE_START = 8; // 0.1 % In
	localparam int LS_IDMT_CAP = 25;
	typedef logic [DW-1:0] word_t;
	localparam word_t SET_MIN [NSET] = '{16'h0005, 16'h0005, 16'h0005,
		16'h0005, 16'h0004, 16'h0014, 16'h000a, 16'h000a, 16'h0014};
	localparam word_t SET_MAX [NSET] = '{16'h0032, 16'h7530, 16'h0064,
		16'h0190, 16'h7530, 16'h0320, 16'h00fa, 16'h7530, 16'h05dc};
	// Display codes
	localparam logic [3:0] CODE_NONE   = 4'h0;
	localparam logic [3:0] CODE_LS_ST  = 4'h1;
	localparam logic [3:0] CODE_LS_TR  = 4'h2;
	localparam logic [3:0] CODE_HS_ST  = 4'h3;
	localparam logic [3:0] CODE_HS_TR  = 4'h4;
	localparam logic [3:0] CODE_RV_ST  = 4'h5;
	localparam logic [3:0] CODE_LE_ST  = 4'h6;
	localparam logic [3:0] CODE_LE_TR  = 4'h7;
	localparam logic [3:0] CODE_HE_TR  = 4'h8;
	localparam logic [3:0] CODE_BF_OP  = 4'h9;
	// Supervision delay
	localparam int ALARM_DELAY_S = 60;
	localparam int CLK_HZ        = 20_000_000;
	localparam longint ALARM_CYCLES = longint'(ALARM_DELAY_S) * CLK_HZ;
	// Stage event carrier
	typedef struct packed {
		logic ls_start;
		logic ls_trip;
		logic hs_start;
		logic hs_trip;
		logic rv_start;
		logic le_start;
		logic le_trip;
		logic he_trip;
		logic bf_op;
	} stage_ev_s;
	// Effective settings carrier
	typedef struct packed {
		word_t ls_start;
		word_t ls_time;
		word_t ls_mult;
		logic  ls_idmt;
		word_t hs_start;
		word_t hs_time;
		logic  hs_enable;
		word_t rv_start;
		word_t le_start;
		word_t le_time;
		word_t he_start;
		logic  he_enable;
	} eff_set_s;
	// Display carrier
	typedef struct packed {
		logic       fault_lead_red;
		logic [3:0] code;
		logic       code_green;
		word_t      value;
		logic [15:0] indicator;
	} display_s;
endpackage : prot_ind_pkg

// File: prot_ind.sv
// Indication, supervision and setting logic of the protection module
//
// Summary of operation
// - Stage events show codes 1..9 on the display.
// - Any stage operation lights one common red trip indicator.
// - Start indication clears itself when its stage resets, unless latching.
// - Group three switches 1..4 make start indications latch until reset.
// - Operation code stays displayed after stage reset until a reset.
// - Permanent internal fault lights alarm and relay about one minute later.
// - Internal fault shows red leading one plus green fault code.
// - Setting value shown with its indicator lit.
// - Low-set start 0.5..5.0; inverse time caps it at 2.5.
// - Low-set time 0.05..300 s used only with definite time.
// - Time multiplier 0.05..1.00 used only with inverse time.
// - High-set time 0.04..300 s is that stage's delay.
// - Residual voltage start 2.0..80.0 percent.
// - Low earth-fault start 1.0..25.0 percent, time 0.1..300 s.
// - High earth-fault start 2.0..150 percent; switch 8 disables it.
// - Checksums of main switch groups and submenu groups are displayable.
// - Light reset clears outputs only; heavy reset also erases records.
`timescale 1ns/1ps
`default_nettype none
module prot_ind
	import prot_ind_pkg::*;
#(
	parameter longint ALARM_DELAY_CYC = ALARM_CYCLES
)(
	input  wire logic                    core_clk,
	input  wire logic                    resetn,
	input  wire logic                    clk_en,
	input  wire logic [AW-1:0]           addr,
	input  wire logic [DW-1:0]           wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic [DW-1:0]                rdata,
	input  wire prot_ind_pkg::stage_ev_s stage_ev,
	input  wire logic                    internal_fault_pin,
	input  wire logic [3:0]              fault_code,
	input  wire logic                    program_btn_pin,
	input  wire logic                    reset_program_btn_pin,
	input  wire logic                    ext_reset_pin,
	output prot_ind_pkg::display_s       display,
	output prot_ind_pkg::eff_set_s       eff_set,
	output logic                         trip_led,
	output logic                         self_supervision_alarm,
	output logic                         supervision_relay,
	output logic                         irq
);
	import prot_ind_pkg::*;

	// Delay counter is 31 bits wide
	if (ALARM_DELAY_CYC < 1 || ALARM_DELAY_CYC > 64'h7fff_ffff) begin : g_bad_dly
		$error("ALARM_DELAY_CYC out of range");
	end

	function automatic word_t clamp(input word_t v, input int idx);
		if (v < SET_MIN[idx])
			return SET_MIN[idx];
		if (v > SET_MAX[idx])
			return SET_MAX[idx];
		return v;
	endfunction : clamp

	function automatic logic pin_edge(input logic [2:0] s, input logic st);
		return (s[1] == s[2]) && (s[2] != st);
	endfunction : pin_edge

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic [1:0] rst_sync_ff;
	logic       rst_n;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	logic [2:0] flt_sync_ff, pb_sync_ff, rpb_sync_ff, ext_sync_ff;
	logic       flt_ff, pb_ff, rpb_ff, ext_ff;
	logic       pb_rise, rpb_rise, ext_rise;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flt_sync_ff <= 3'h0;
			pb_sync_ff  <= 3'h0;
			rpb_sync_ff <= 3'h0;
			ext_sync_ff <= 3'h0;
			flt_ff      <= 1'b0;
			pb_ff       <= 1'b0;
			rpb_ff      <= 1'b0;
			ext_ff      <= 1'b0;
		end else if (clk_en) begin
			flt_sync_ff <= {flt_sync_ff[1:0], internal_fault_pin};
			pb_sync_ff  <= {pb_sync_ff[1:0], program_btn_pin};
			rpb_sync_ff <= {rpb_sync_ff[1:0], reset_program_btn_pin};
			ext_sync_ff <= {ext_sync_ff[1:0], ext_reset_pin};
			if (flt_sync_ff[1] == flt_sync_ff[2])
				flt_ff <= flt_sync_ff[2];
			if (pb_sync_ff[1] == pb_sync_ff[2])
				pb_ff <= pb_sync_ff[2];
			if (rpb_sync_ff[1] == rpb_sync_ff[2])
				rpb_ff <= rpb_sync_ff[2];
			if (ext_sync_ff[1] == ext_sync_ff[2])
				ext_ff <= ext_sync_ff[2];
		end
	end
	assign pb_rise  = pin_edge(pb_sync_ff, pb_ff) && pb_sync_ff[2];
	assign rpb_rise = pin_edge(rpb_sync_ff, rpb_ff) && rpb_sync_ff[2];
	assign ext_rise = pin_edge(ext_sync_ff, ext_ff) && ext_sync_ff[2];

	////////////////////////////////////////////////////////////////////////
	// Register file
	logic [7:0]  function_switches_one_ff, function_switches_two_ff;
	logic [7:0]  function_switches_three_ff;
	logic [7:0]  blocking_switches_one_ff, output_routing_switches_one_ff;
	logic [3:0]  dsel_ff;
	word_t       set_ff [NSET];
	logic [NIRQ-1:0] irq_mask_ff;
	logic        sw_keep, sw_erase, reset_keep, reset_erase, reset_any;
	logic        wr_en;
	assign wr_en    = wr && clk_en;
	assign sw_keep  = wr_en && addr == REG_CMD && wdata[CMD_KEEP];
	assign sw_erase = wr_en && addr == REG_CMD && wdata[CMD_ERASE];
	assign reset_keep  = pb_rise || sw_keep;
	assign reset_erase = rpb_rise || ext_rise || sw_erase;
	assign reset_any   = reset_keep || reset_erase;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			function_switches_one_ff       <= 8'h00;
			function_switches_two_ff       <= 8'h00;
			function_switches_three_ff     <= 8'h00;
			blocking_switches_one_ff       <= 8'h00;
			output_routing_switches_one_ff <= 8'h00;
			dsel_ff                        <= 4'h0;
			irq_mask_ff                    <= '0;
		end else if (wr_en) begin
			unique case (addr)
				REG_FUNC1: function_switches_one_ff <= wdata[7:0];
				REG_FUNC2: function_switches_two_ff <= wdata[7:0];
				REG_FUNC3: function_switches_three_ff <= wdata[7:0];
				REG_BLOCK1: blocking_switches_one_ff <= wdata[7:0];
				REG_ROUTE1: output_routing_switches_one_ff <= wdata[7:0];
				REG_DSEL: dsel_ff <= wdata[3:0];
				REG_IRQ_MASK: irq_mask_ff <= wdata[NIRQ-1:0];
				default: ;
			endcase
		end
	end

	for (genvar i = 0; i < NSET; i++) begin : g_set
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n)
				set_ff[i] <= SET_MIN[i];
			else if (wr_en && addr == REG_SET0 + 5'(i))
				set_ff[i] <= clamp(wdata, i);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Effective settings toward the stage logic
	logic ls_idmt;
	assign ls_idmt = function_switches_one_ff[FUNC1_CHAR_LSB +: 3] != 3'h0;
	always_comb begin
		eff_set          = '0;
		eff_set.ls_idmt  = ls_idmt;
		eff_set.ls_start = (ls_idmt && set_ff[S_LS_START] > LS_IDMT_CAP)
			? word_t'(LS_IDMT_CAP) : set_ff[S_LS_START];
		eff_set.ls_time  = ls_idmt ? '0 : set_ff[S_LS_TIME];
		eff_set.ls_mult  = ls_idmt ? set_ff[S_LS_MULT] : '0;
		eff_set.hs_enable = !function_switches_one_ff[FUNC1_HS_INF];
		eff_set.hs_start = set_ff[S_HS_START];
		eff_set.hs_time  = set_ff[S_HS_TIME];
		eff_set.rv_start = set_ff[S_RV_START];
		eff_set.le_start = set_ff[S_LE_START];
		eff_set.le_time  = set_ff[S_LE_TIME];
		eff_set.he_enable = !function_switches_one_ff[FUNC1_HEF_INF];
		eff_set.he_start = set_ff[S_HE_START];
	end

	////////////////////////////////////////////////////////////////////////
	// Start and operation indications
	logic [3:0] start_ind_ff;
	logic [3:0] start_now;
	logic [4:0] op_ind_ff;
	logic [4:0] op_now;
	logic [3:0] latch_sel;
	logic [DW-1:0] record_ff;
	assign start_now = {stage_ev.le_start, stage_ev.rv_start,
		stage_ev.hs_start, stage_ev.ls_start};
	assign op_now = {stage_ev.bf_op, stage_ev.he_trip, stage_ev.le_trip,
		stage_ev.hs_trip, stage_ev.ls_trip};
	assign latch_sel = function_switches_three_ff[3:0];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_ind_ff <= 4'h0;
		end else if (clk_en) begin
			for (int i = 0; i < 4; i++) begin
				if (start_now[i])
					start_ind_ff[i] <= 1'b1;
				else if (!latch_sel[i] || reset_any)
					start_ind_ff[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			op_ind_ff <= 5'h00;
		else if (clk_en)
			op_ind_ff <= op_now | (reset_any ? 5'h00 : op_ind_ff);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			record_ff <= '0;
		else if (clk_en) begin
			if (reset_erase)
				record_ff <= '0;
			else if (|(op_now & ~op_ind_ff))
				record_ff <= record_ff + 16'h0001;
		end
	end

	assign trip_led = |op_ind_ff;

	////////////////////////////////////////////////////////////////////////
	// Self-supervision delay
	logic [30:0] alarm_cnt_ff;
	logic        alarm_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_cnt_ff <= '0;
			alarm_ff     <= 1'b0;
		end else if (clk_en) begin
			if (!flt_ff) begin
				alarm_cnt_ff <= '0;
				alarm_ff     <= 1'b0;
			end else if (alarm_cnt_ff != 31'(ALARM_DELAY_CYC - 1)) begin
				alarm_cnt_ff <= alarm_cnt_ff + 31'h1;
			end else begin
				alarm_ff <= 1'b1;
			end
		end
	end
	assign self_supervision_alarm = alarm_ff;
	assign supervision_relay      = alarm_ff;

	////////////////////////////////////////////////////////////////////////
	// Display selection
	logic [3:0] ind_code;
	always_comb begin
		ind_code = CODE_NONE;
		if (start_ind_ff[0]) ind_code = CODE_LS_ST;
		if (op_ind_ff[0])    ind_code = CODE_LS_TR;
		if (start_ind_ff[1]) ind_code = CODE_HS_ST;
		if (op_ind_ff[1])    ind_code = CODE_HS_TR;
		if (start_ind_ff[2]) ind_code = CODE_RV_ST;
		if (start_ind_ff[3]) ind_code = CODE_LE_ST;
		if (op_ind_ff[2])    ind_code = CODE_LE_TR;
		if (op_ind_ff[3])    ind_code = CODE_HE_TR;
		if (op_ind_ff[4])    ind_code = CODE_BF_OP;
	end

	display_s nxt_display;
	always_comb begin
		nxt_display = '0;
		nxt_display.indicator[dsel_ff] = 1'b1;
		if (dsel_ff < 4'(NSET))
			nxt_display.value = set_ff[dsel_ff];
		else begin
			unique case (dsel_ff)
				4'h9: nxt_display.value = 16'(function_switches_one_ff);
				4'ha: nxt_display.value = 16'(blocking_switches_one_ff);
				4'hb: nxt_display.value = 16'(output_routing_switches_one_ff);
				4'hc: nxt_display.value = 16'(function_switches_two_ff);
				4'hd: nxt_display.value = 16'(function_switches_three_ff);
				default: nxt_display.value = '0;
			endcase
		end
		if (alarm_ff) begin
			nxt_display.fault_lead_red = 1'b1;
			nxt_display.code_green     = 1'b1;
			nxt_display.code           = fault_code;
		end else
			nxt_display.code = ind_code;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			display <= '0;
		else if (clk_en)
			display <= nxt_display;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts and read port
	logic [NIRQ-1:0] irq_stat_ff, irq_set;
	assign irq_set = {flt_ff && !alarm_ff
		&& alarm_cnt_ff == 31'(ALARM_DELAY_CYC - 1),
		|(op_now & ~op_ind_ff), |(start_now & ~start_ind_ff)};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			irq_stat_ff <= '0;
		else if (clk_en) begin
			if (wr && addr == REG_IRQ_STAT)
				irq_stat_ff <= (irq_stat_ff & ~wdata[NIRQ-1:0]) | irq_set;
			else
				irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end
	assign irq = |(irq_stat_ff & irq_mask_ff);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rdata <= '0;
		else if (clk_en) begin
			rdata <= '0;
			if (rd) begin
				unique case (addr)
					REG_FUNC1: rdata <= 16'(function_switches_one_ff);
					REG_FUNC2: rdata <= 16'(function_switches_two_ff);
					REG_FUNC3: rdata <= 16'(function_switches_three_ff);
					REG_BLOCK1: rdata <= 16'(blocking_switches_one_ff);
					REG_ROUTE1: rdata <= 16'(output_routing_switches_one_ff);
					REG_DSEL: rdata <= 16'(dsel_ff);
					REG_IRQ_STAT: rdata <= 16'(irq_stat_ff);
					REG_IRQ_MASK: rdata <= 16'(irq_mask_ff);
					REG_IND: rdata <= {6'h0, alarm_ff, op_ind_ff, start_ind_ff};
					REG_RECORD: rdata <= record_ff;
					default: begin
						if (addr >= REG_SET0 && addr < REG_SET0 + 5'(NSET))
							rdata <= set_ff[4'(addr - REG_SET0)];
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_code_bf;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && op_ind_ff[4] && !alarm_ff) |=> display.code == CODE_BF_OP;
	endproperty
	a_code_bf: assert property (p_code_bf) else $error("code 9 missing");

	property p_trip_led;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && |op_now) |=> trip_led;
	endproperty
	a_trip_led: assert property (p_trip_led) else $error("trip led off");

	property p_self_reset;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && !start_now[0] && !latch_sel[0]) |=> !start_ind_ff[0];
	endproperty
	a_self_reset: assert property (p_self_reset) else $error("no self reset");

	property p_latch;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && start_ind_ff[0] && latch_sel[0] && !reset_any)
			|=> start_ind_ff[0];
	endproperty
	a_latch: assert property (p_latch) else $error("latch lost");

	property p_op_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && op_ind_ff[2] && !reset_any) |=> op_ind_ff[2];
	endproperty
	a_op_hold: assert property (p_op_hold) else $error("op code lost");

	property p_alarm_cause;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(alarm_ff) |-> $past(flt_ff) && supervision_relay;
	endproperty
	a_alarm_cause: assert property (p_alarm_cause) else $error("bad alarm");

	property p_ls_cap;
		@(posedge core_clk) disable iff (!rst_n)
		ls_idmt |-> eff_set.ls_start <= word_t'(LS_IDMT_CAP);
	endproperty
	a_ls_cap: assert property (p_ls_cap) else $error("cap exceeded");

	property p_range;
		@(posedge core_clk) disable iff (!rst_n)
		(set_ff[S_HE_START] >= SET_MIN[S_HE_START])
			&& (set_ff[S_HE_START] <= SET_MAX[S_HE_START]);
	endproperty
	a_range: assert property (p_range) else $error("setting out of range");

	c_trip: cover property (@(posedge core_clk) disable iff (!rst_n)
		$rose(trip_led));
	c_alarm: cover property (@(posedge core_clk) disable iff (!rst_n)
		$rose(self_supervision_alarm));
	c_erase: cover property (@(posedge core_clk) disable iff (!rst_n)
		reset_erase && record_ff != '0);
endmodule : prot_ind
`default_nettype wire

// File: stage_model.sv
// Stage logic and internal fault source feeding the indication block
`timescale 1ns/1ps
`default_nettype none
module stage_model (
	input  wire logic                    core_clk,
	input  wire prot_ind_pkg::stage_ev_s ev_req,
	input  wire logic                    fault_req,
	input  wire logic [3:0]              code_req,
	output prot_ind_pkg::stage_ev_s      stage_ev,
	output logic                         internal_fault_pin,
	output logic [3:0]                   fault_code
);
	import prot_ind_pkg::*;

	// Stage levels leave the stage logic on the shared clock
	always_ff @(posedge core_clk) begin
		stage_ev <= ev_req;
	end

	always_ff @(posedge core_clk) begin
		fault_code <= code_req;
	end

	// Fault line is asynchronous to the block
	assign internal_fault_pin = fault_req;
endmodule : stage_model
`default_nettype wire

// File: tb_prot_ind.sv
// Self-checking bench for the protection indication block
`timescale 1ns/1ps
`default_nettype none
module tb_prot_ind;
	import prot_ind_pkg::*;
	localparam int          DLY    = 20;
	localparam logic [15:0] CK [5] = '{16'h00a5, 16'h003c, 16'h005a,
		16'h0096, 16'h0000};
	logic        core_clk, resetn, wr, rd, fault_req, ifp, irq, clk_en;
	logic        prog_btn, rst_btn, ext_rst, trip_led, alarm, relay;
	logic [4:0]  addr;
	logic [15:0] wdata, rdata, v;
	logic [3:0]  code_req, fcode;
	stage_ev_s   ev_req, stage_ev;
	display_s    display;
	eff_set_s    eff_set;
	int          bad_count, compares;

	prot_ind #(.ALARM_DELAY_CYC(DLY)) dut (
		.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.stage_ev(stage_ev), .internal_fault_pin(ifp),
		.fault_code(fcode), .program_btn_pin(prog_btn),
		.reset_program_btn_pin(rst_btn), .ext_reset_pin(ext_rst),
		.display(display), .eff_set(eff_set), .trip_led(trip_led),
		.self_supervision_alarm(alarm), .supervision_relay(relay),
		.irq(irq));

	stage_model partner (
		.core_clk(core_clk), .ev_req(ev_req), .fault_req(fault_req),
		.code_req(code_req), .stage_ev(stage_ev),
		.internal_fault_pin(ifp), .fault_code(fcode));

	////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic test_done;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic wreg(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rreg

	task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rreg(a, d);
		chk(d, exp);
	endtask : rchk

	task automatic ev(input int idx, input logic val);
		@(posedge core_clk);
		ev_req[idx] <= val;
	endtask : ev

	////////////////////////////////////////////////////////////////////
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		ev_req = '0;
		fault_req = 1'b0;
		code_req = 4'h0;
		prog_btn = 1'b0;
		rst_btn = 1'b0;
		ext_rst = 1'b0;
		bad_count = 0;
		compares = 0;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		cyc(6);
		rchk(5'h1f, 16'h0000);
		// Settings start at minimum and clamp both ways
		for (int i = 0; i < NSET; i++) begin
			rchk(REG_SET0 + 5'(i), SET_MIN[i]);
			wreg(REG_SET0 + 5'(i), 16'hffff);
			rchk(REG_SET0 + 5'(i), SET_MAX[i]);
			wreg(REG_SET0 + 5'(i), 16'h0000);
			rchk(REG_SET0 + 5'(i), SET_MIN[i]);
		end
		wreg(REG_SET0, 16'h0032);
		wreg(REG_SET0 + 5'(S_LS_MULT), 16'h0020);
		wreg(REG_FUNC1, 16'h00c0);
		cyc(1);
		chk(eff_set.ls_start, 16'h0032);
		chk(eff_set.ls_mult, 16'h0000);
		chk(eff_set.ls_time, SET_MIN[S_LS_TIME]);
		chk(eff_set.hs_start, SET_MIN[S_HS_START]);
		chk(eff_set.hs_time, SET_MIN[S_HS_TIME]);
		chk(eff_set.rv_start, SET_MIN[S_RV_START]);
		chk(eff_set.le_start, SET_MIN[S_LE_START]);
		chk(eff_set.le_time, SET_MIN[S_LE_TIME]);
		chk(eff_set.he_start, SET_MIN[S_HE_START]);
		chk(16'(eff_set.hs_enable), 16'h0000);
		chk(16'(eff_set.he_enable), 16'h0000);
		wreg(REG_FUNC1, 16'h0001);
		cyc(1);
		chk(eff_set.ls_start, 16'(LS_IDMT_CAP));
		chk(eff_set.ls_time, 16'h0000);
		chk(eff_set.ls_mult, 16'h0020);
		chk(16'(eff_set.ls_idmt), 16'h0001);
		chk(16'({eff_set.hs_enable, eff_set.he_enable}), 16'h3);
		// Self-reset and latched start indication
		ev(8, 1'b1);
		cyc(4);
		chk(16'(display.code), 16'h0001);
		ev(8, 1'b0);
		cyc(4);
		chk(16'(display.code), 16'h0000);
		wreg(REG_FUNC3, 16'h0001);
		ev(8, 1'b1);
		ev(8, 1'b0);
		cyc(4);
		chk(16'(display.code), 16'h0001);
		@(posedge core_clk);
		prog_btn <= 1'b1;
		cyc(10);
		chk(16'(display.code), 16'h0000);
		prog_btn <= 1'b0;
		wreg(REG_FUNC3, 16'h0000);
		// Every stage event in turn; operations stay shown
		for (int i = 0; i < 9; i++) begin
			ev(8 - i, 1'b1);
			cyc(4);
			chk(16'(display.code), 16'(i + 1));
			ev(8 - i, 1'b0);
		end
		cyc(4);
		chk(16'({trip_led, display.code}), 16'h0019);
		rchk(REG_IRQ_STAT, 16'h0003);
		wreg(REG_IRQ_MASK, 16'h0000);
		cyc(1);
		v[0] = irq;
		wreg(REG_IRQ_MASK, 16'h0007);
		cyc(1);
		chk(16'(v[0] ^ irq), 16'h0001);
		wreg(REG_IRQ_STAT, 16'h0007);
		cyc(1);
		chk(16'(irq), 16'h0000);
		rchk(REG_IRQ_STAT, 16'h0000);
		// Light reset keeps records, heavy reset erases them
		rreg(REG_RECORD, v);
		chk(v, 16'h0005);
		wreg(REG_CMD, 16'h0001);
		cyc(2);
		chk(16'({trip_led, display.code}), 16'h0000);
		rchk(REG_RECORD, v);
		@(posedge core_clk);
		ext_rst <= 1'b1;
		rst_btn <= 1'b1;
		cyc(10);
		ext_rst <= 1'b0;
		rst_btn <= 1'b0;
		rchk(REG_RECORD, 16'h0000);
		// Frozen block ignores a trip pulse
		@(posedge core_clk);
		clk_en <= 1'b0;
		ev(7, 1'b1);
		ev(7, 1'b0);
		cyc(4);
		chk(16'({trip_led, display.code}), 16'h0000);
		@(posedge core_clk);
		clk_en <= 1'b1;
		// Display selection: settings and switch checksums
		wreg(REG_FUNC1, CK[0]);
		wreg(REG_BLOCK1, CK[1]);
		wreg(REG_ROUTE1, CK[2]);
		wreg(REG_FUNC2, CK[3]);
		for (int s = 0; s < 14; s++) begin
			wreg(REG_DSEL, 16'(s));
			cyc(2);
			chk(display.value, s == 0 ? 16'h0032 : s == 2 ? 16'h0020 :
				s < 9 ? SET_MIN[s] : CK[s - 9]);
			chk(display.indicator, 16'h0001 << s);
		end
		// Internal fault raises the delayed alarm with its code
		@(posedge core_clk);
		fault_req <= 1'b1;
		code_req <= 4'h5;
		cyc(12);
		chk(16'({alarm, relay}), 16'h0000);
		cyc(24);
		chk(16'({alarm, relay}), 16'h0003);
		chk(16'({display.fault_lead_red, display.code_green,
			display.code}), 16'h0035);
		rchk(REG_IRQ_STAT, 16'h0004);
		test_done();
	end

	initial begin
		#2_000_000;
		bad_count++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end
endmodule : tb_prot_ind
`default_nettype wire
